// ---- lpss_pkg.sv ----
// Constants shared by the lens position sense sequencer and its helpers.
// Assumes a single 10 MHz clock domain and an 8-bit register port.
package lpss_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned US_PER_S = 1_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
	localparam logic [9:0] SETTLE_MAX_US = 10'd1000;
	localparam int unsigned ADC_W = 12;
	localparam int unsigned AVG_SAMPLES = 4;
	localparam int unsigned AVG_SHIFT = 2;
	// Register offsets on the 4-bit address port.
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_LED = 4'h1;
	localparam logic [3:0] ADDR_SETTLE_LO = 4'h2;
	localparam logic [3:0] ADDR_SETTLE_HI = 4'h3;
	localparam logic [3:0] ADDR_RESULT_LO = 4'h4;
	localparam logic [3:0] ADDR_RESULT_HI = 4'h5;
	localparam logic [3:0] ADDR_THRESH_LO = 4'h6;
	localparam logic [3:0] ADDR_THRESH_HI = 4'h7;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h9;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hA;
	localparam logic [3:0] ADDR_CLKDIV = 4'hB;
	// Control register fields.
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_AVG_EN = 1;
	localparam int unsigned CTRL_VOLT = 2;
	localparam int unsigned CTRL_ZOOM = 3;
	localparam int unsigned CTRL_CMP_EN = 4;
	localparam logic [7:0] CTRL_MASK = 8'h1E;
	// Status and interrupt fields.
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_HIT = 1;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_HIT = 1;
	// Reset values.
	localparam logic [7:0] CTRL_RST = 8'h02;
	localparam logic [3:0] LED_RST = 4'h0;
	localparam logic [9:0] SETTLE_RST = 10'h000;
	localparam logic [11:0] THRESH_RST = 12'hFFF;
	localparam logic [7:0] CLKDIV_RST = 8'h04;
endpackage

// ---- lpss_clk_div.sv ----
// Converter clock generator: divides the master clock by 2*(div+1).
// Assumes div is a static register value from the same clock domain.
`timescale 1ns/1ps
module lpss_clk_div (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Divide setting
	input wire logic [7:0] div,
	// Divided clock
	output logic conv_clk
);
	import lpss_pkg::*;
	logic [7:0] cnt_reg, cnt_next;
	logic clk_reg, clk_next;

	always_comb begin
		cnt_next = cnt_reg + 8'h01;
		clk_next = clk_reg;
		if (cnt_reg >= div) begin
			cnt_next = 8'h00;
			clk_next = ~clk_reg;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_reg <= 8'h00;
			clk_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			clk_reg <= clk_next;
		end
	end

	assign conv_clk = clk_reg;
endmodule

// ---- lpss_avg.sv ----
// Sample accumulator: sums up to four converter words and yields the mean.
// Assumes clear precedes each measurement and add is a one-cycle pulse.
`timescale 1ns/1ps
module lpss_avg (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Control
	input wire logic clear,
	input wire logic add,
	input wire logic avg_en,
	// Sample in
	input wire logic [11:0] sample,
	// Result out
	output logic [11:0] mean
);
	import lpss_pkg::*;
	logic [13:0] sum_reg, sum_next;

	always_comb begin
		sum_next = sum_reg;
		if (clear) begin
			sum_next = 14'h0000;
		end else if (add) begin
			sum_next = sum_reg + {2'b00, sample};
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sum_reg <= 14'h0000;
		end else begin
			sum_reg <= sum_next;
		end
	end

	// The mean truncates rather than rounds, which keeps the path a plain shift.
	assign mean = avg_en ? sum_reg[13:2] : sum_reg[11:0];
endmodule

// ---- lpss_seq.sv ----
// Lens position sense sequencer: settle, convert, average, store, compare.
// Assumes a converter that raises conv_done after conv_start until the next start,
// with conv_data stable while conv_done is high; both arrive unsynchronised.
`timescale 1ns/1ps
module lpss_seq #(
	parameter int unsigned US_CYCLES = lpss_pkg::CYC_PER_US
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Converter
	output logic conv_clk,
	output logic conv_start,
	output logic adc_voltage_mode,
	input wire logic conv_done,
	input wire logic [lpss_pkg::ADC_W-1:0] conv_data,
	// Sensor drive
	output logic [3:0] led_current_source,
	output logic focus_led_en,
	output logic zoom_led_en,
	output logic zoom_hall_supply,
	// Actuator and interrupt
	output logic driver_disable,
	output logic irq
);
	import lpss_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_START, S_WAIT, S_STORE} lpss_state_t;

	function automatic logic hit_write(input logic [3:0] a, input logic [3:0] r, input logic w);
		hit_write = w && (a == r);
	endfunction

	// Threshold reached means at or above it, and only while the compare is switched on.
	function automatic logic reaches(input logic [11:0] v, input logic [11:0] t, input logic en);
		reaches = en && (v >= t);
	endfunction

	// Focus LED, zoom LED and zoom Hall supply, in that order; at most one is ever live.
	function automatic logic [2:0] sense_sel(input logic active, input logic volt, input logic zoom);
		sense_sel = 3'h0;
		if (active) begin
			if (!volt) begin
				sense_sel = zoom ? 3'h2 : 3'h1;
			end else if (zoom) begin
				sense_sel = 3'h4;
			end
		end
	endfunction

	// Register state.
	logic [7:0] ctrl_reg, ctrl_next;
	logic [3:0] led_reg, led_next;
	logic [9:0] settle_reg, settle_next;
	logic [11:0] thresh_reg, thresh_next;
	logic [11:0] result_reg, result_next;
	logic [1:0] irq_stat_reg, irq_stat_next;
	logic [1:0] irq_mask_reg, irq_mask_next;
	logic [7:0] div_reg, div_next;
	logic [7:0] rdata_reg, rdata_next;
	logic hit_reg, hit_next;
	// Sequencer state.
	lpss_state_t state_reg, state_next;
	logic [13:0] tmr_reg, tmr_next;
	logic [2:0] cnt_reg, cnt_next;
	logic start_reg, start_next;
	// Converter input synchroniser.
	logic done_s1_reg, done_s2_reg, done_s3_reg;
	logic [11:0] data_s1_reg, data_s2_reg;
	logic done_rise;
	logic go;
	logic clear_acc;
	logic add_acc;
	logic store;
	logic [11:0] mean;
	logic [9:0] settle_eff;
	logic [13:0] settle_cyc;
	logic busy;
	logic [2:0] sense_drive;

	// Two flops per pin before any logic looks at the converter.
	always_ff @(posedge clock) begin
		if (rst) begin
			done_s1_reg <= 1'b0;
			done_s2_reg <= 1'b0;
			done_s3_reg <= 1'b0;
			data_s1_reg <= 12'h000;
			data_s2_reg <= 12'h000;
		end else begin
			done_s1_reg <= conv_done;
			done_s2_reg <= done_s1_reg;
			done_s3_reg <= done_s2_reg;
			data_s1_reg <= conv_data;
			data_s2_reg <= data_s1_reg;
		end
	end

	// Data is taken in the same cycle as the synchronised done edge, having passed both stages alongside done.
	assign done_rise = done_s3_reg && !done_s2_reg ? 1'b0 : (done_s2_reg && !done_s3_reg);
	assign go = hit_write(addr, ADDR_CTRL, wr) && wdata[CTRL_START];
	assign settle_eff = (settle_reg > SETTLE_MAX_US) ? SETTLE_MAX_US : settle_reg;
	assign settle_cyc = 14'(settle_eff * US_CYCLES);
	assign busy = (state_reg != S_IDLE);

	// Sequencer.
	always_comb begin
		state_next = state_reg;
		tmr_next = tmr_reg;
		cnt_next = cnt_reg;
		start_next = 1'b0;
		clear_acc = 1'b0;
		add_acc = 1'b0;
		store = 1'b0;
		unique case (state_reg)
			S_IDLE: begin
				if (go) begin
					clear_acc = 1'b1;
					tmr_next = 14'h0000;
					cnt_next = 3'h0;
					state_next = S_SETTLE;
				end
			end
			S_SETTLE: begin
				if (tmr_reg >= settle_cyc) begin
					state_next = S_START;
				end else begin
					tmr_next = tmr_reg + 14'h0001;
				end
			end
			S_START: begin
				start_next = 1'b1;
				state_next = S_WAIT;
			end
			S_WAIT: begin
				if (done_rise) begin
					add_acc = 1'b1;
					cnt_next = cnt_reg + 3'h1;
					if (!ctrl_reg[CTRL_AVG_EN] || cnt_reg == 3'(AVG_SAMPLES - 1)) begin
						state_next = S_STORE;
					end else begin
						state_next = S_START;
					end
				end
			end
			S_STORE: begin
				store = 1'b1;
				state_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= S_IDLE;
			tmr_reg <= 14'h0000;
			cnt_reg <= 3'h0;
			start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			cnt_reg <= cnt_next;
			start_reg <= start_next;
		end
	end

	lpss_avg u_avg (
		.clock(clock),
		.rst(rst),
		.clear(clear_acc),
		.add(add_acc),
		.avg_en(ctrl_reg[CTRL_AVG_EN]),
		.sample(data_s2_reg),
		.mean(mean)
	);

	lpss_clk_div u_div (
		.clock(clock),
		.rst(rst),
		.div(div_reg),
		.conv_clk(conv_clk)
	);

	// Register file, result store, comparator and interrupt flags.
	always_comb begin
		ctrl_next = ctrl_reg;
		led_next = led_reg;
		settle_next = settle_reg;
		thresh_next = thresh_reg;
		result_next = result_reg;
		irq_mask_next = irq_mask_reg;
		div_next = div_reg;
		hit_next = hit_reg;
		irq_stat_next = irq_stat_reg;
		rdata_next = 8'h00;
		// Mode bits are frozen mid-sequence so one measurement never mixes sensors or modes.
		if (hit_write(addr, ADDR_CTRL, wr) && state_reg == S_IDLE) begin
			ctrl_next = wdata & CTRL_MASK;
		end
		if (hit_write(addr, ADDR_LED, wr)) begin
			led_next = wdata[3:0];
		end
		if (hit_write(addr, ADDR_SETTLE_LO, wr)) begin
			settle_next[7:0] = wdata;
		end
		if (hit_write(addr, ADDR_SETTLE_HI, wr)) begin
			settle_next[9:8] = wdata[1:0];
		end
		if (hit_write(addr, ADDR_THRESH_LO, wr)) begin
			thresh_next[7:0] = wdata;
		end
		if (hit_write(addr, ADDR_THRESH_HI, wr)) begin
			thresh_next[11:8] = wdata[3:0];
		end
		if (hit_write(addr, ADDR_IRQ_MASK, wr)) begin
			irq_mask_next = wdata[1:0];
		end
		if (hit_write(addr, ADDR_CLKDIV, wr)) begin
			div_next = wdata;
		end
		if (hit_write(addr, ADDR_IRQ_STAT, wr)) begin
			irq_stat_next = irq_stat_reg & ~wdata[1:0];
		end
		if (store) begin
			result_next = mean;
			hit_next = reaches(mean, thresh_reg, ctrl_reg[CTRL_CMP_EN]);
			irq_stat_next[IRQ_DONE] = 1'b1;
			if (reaches(mean, thresh_reg, ctrl_reg[CTRL_CMP_EN])) begin
				irq_stat_next[IRQ_HIT] = 1'b1;
			end
		end
		if (!ctrl_next[CTRL_CMP_EN]) begin
			hit_next = 1'b0;
		end
		if (rd) begin
			unique case (addr)
				ADDR_CTRL: rdata_next = ctrl_reg;
				ADDR_LED: rdata_next = {4'h0, led_reg};
				ADDR_SETTLE_LO: rdata_next = settle_reg[7:0];
				ADDR_SETTLE_HI: rdata_next = {6'h00, settle_reg[9:8]};
				ADDR_RESULT_LO: rdata_next = result_reg[7:0];
				ADDR_RESULT_HI: rdata_next = {4'h0, result_reg[11:8]};
				ADDR_THRESH_LO: rdata_next = thresh_reg[7:0];
				ADDR_THRESH_HI: rdata_next = {4'h0, thresh_reg[11:8]};
				ADDR_STATUS: rdata_next = {6'h00, hit_reg, busy};
				ADDR_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
				ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
				ADDR_CLKDIV: rdata_next = div_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_reg <= CTRL_RST;
			led_reg <= LED_RST;
			settle_reg <= SETTLE_RST;
			thresh_reg <= THRESH_RST;
			result_reg <= 12'h000;
			irq_stat_reg <= 2'h0;
			irq_mask_reg <= 2'h0;
			div_reg <= CLKDIV_RST;
			hit_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			ctrl_reg <= ctrl_next;
			led_reg <= led_next;
			settle_reg <= settle_next;
			thresh_reg <= thresh_next;
			result_reg <= result_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			div_reg <= div_next;
			hit_reg <= hit_next;
			rdata_reg <= rdata_next;
		end
	end

	// Sensor drive is live only while a measurement runs, and only toward one lens.
	assign sense_drive = sense_sel(busy, ctrl_reg[CTRL_VOLT], ctrl_reg[CTRL_ZOOM]);
	assign focus_led_en = sense_drive[0];
	assign zoom_led_en = sense_drive[1];
	assign zoom_hall_supply = sense_drive[2];
	assign led_current_source = led_reg;
	assign adc_voltage_mode = ctrl_reg[CTRL_VOLT];
	assign conv_start = start_reg;
	assign driver_disable = hit_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);
	assign rdata = rdata_reg;
endmodule

// ---- lpss_seq_assertions.sv ----
// Port checker for the lens position sense sequencer.
// Assumes the converter clock divider stays at its reset setting of 4.
`timescale 1ns/1ps
module lpss_seq_assertions (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic rd,
	input wire logic [7:0] rdata,
	// Converter and sensors
	input wire logic conv_clk,
	input wire logic conv_start,
	input wire logic adc_voltage_mode,
	input wire logic focus_led_en,
	input wire logic zoom_led_en,
	input wire logic zoom_hall_supply,
	input wire logic driver_disable
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_one_sensor: assert property (!(focus_led_en && zoom_led_en)) else $error("both LEDs driven");
	a_led_current: assert property ((focus_led_en || zoom_led_en) |-> !adc_voltage_mode) else $error("LED in volt mode");
	a_hall_volt: assert property (zoom_hall_supply |-> adc_voltage_mode) else $error("hall in current mode");
	a_start_gap: assert property (conv_start |=> !conv_start [*3]) else $error("starts too close");
	a_start_sense: assert property (conv_start |->
		(focus_led_en || zoom_led_en || zoom_hall_supply || adc_voltage_mode)) else $error("start without sensor");
	a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata without read");
	a_clk_period: assert property ($rose(conv_clk) |=> conv_clk [*4] ##1 !conv_clk) else $error("conv clock period");
	a_store_end: assert property ($rose(driver_disable) |->
		!(focus_led_en || zoom_led_en || zoom_hall_supply)) else $error("disable raised mid sequence");
endmodule
bind lpss_seq lpss_seq_assertions chk_u (.clock, .rst, .rd, .rdata, .conv_clk, .conv_start, .adc_voltage_mode,
	.focus_led_en, .zoom_led_en, .zoom_hall_supply, .driver_disable);

// ---- lpss_adc_model.sv ----
// Converter model: answers each start after a chosen latency with base plus sample index.
// Assumes starts come one at a time; clr restarts the index for a new measurement.
`timescale 1ns/1ps
module lpss_adc_model (
	// Clock and control
	input wire logic clock,
	input wire logic clr,
	input wire logic [7:0] lat,
	input wire logic [11:0] base,
	// Converter side
	input wire logic conv_start,
	output logic conv_done,
	output logic [11:0] conv_data
);
	logic [7:0] cnt = 8'h00;
	logic [1:0] idx = 2'h0;
	logic [11:0] last = 12'h000;
	initial conv_done = 1'b0;
	always @(posedge clock) begin
		if (clr)
			idx <= 2'h0;
		if (conv_start) begin
			conv_done <= 1'b0;
			cnt <= lat;
		end else if (cnt == 8'h01) begin
			conv_done <= 1'b1;
			last <= base + 12'(idx);
			idx <= idx + 2'h1;
			cnt <= 8'h00;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end
	end
	// Data is only promised while done is high, so show a wrong value otherwise.
	assign conv_data = conv_done ? last : ~last;
endmodule

// ---- tb_lens_position_sense_sequencer.sv ----
// Testbench for the lens position sense sequencer with a converter model.
// Assumes US_CYCLES of 1, so one settle microsecond lasts one clock.
`timescale 1ns/1ps
module tb_lens_position_sense_sequencer;
	import lpss_pkg::*;
	logic clock = 0, rst = 1, wr = 0, rd = 0, adc_clr = 0, hv = 0;
	logic [3:0] addr = 4'h0, led_current_source;
	logic [7:0] wdata = 8'h00, rdata, lat = 8'h03;
	logic [11:0] conv_data, base = 12'h000, prev = 12'h000;
	logic conv_clk, conv_start, adc_voltage_mode, conv_done, focus_led_en, zoom_led_en, zoom_hall_supply;
	logic driver_disable, irq, ck_d = 1'b0;
	int failures = 0, n_checks = 0, n_st = 0, nf = 0, nz = 0, nh = 0, n_ck = 0;
	always #50 clock = ~clock;
	lpss_seq #(.US_CYCLES(1)) dut_u (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .conv_clk, .conv_start,
		.adc_voltage_mode, .conv_done, .conv_data, .led_current_source, .focus_led_en, .zoom_led_en,
		.zoom_hall_supply, .driver_disable, .irq);
	lpss_adc_model adc_u (.clock, .clr(adc_clr), .lat, .base, .conv_start, .conv_done, .conv_data);
	always @(posedge clock) begin
		n_st <= n_st + int'(conv_start);
		nf <= nf + int'(focus_led_en);
		nz <= nz + int'(zoom_led_en);
		nh <= nh + int'(zoom_hall_supply);
		n_ck <= n_ck + int'(conv_clk && !ck_d);
		ck_d <= conv_clk;
	end
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic meas(input logic [7:0] c, input logic [9:0] su, input logic [11:0] b, input logic [7:0] l);
		int k, sx, s0, f0, z0, h0;
		logic [11:0] e;
		logic [7:0] rl, rh;
		e = c[1] ? b + 12'h001 : b;
		sx = (su > 10'd1000) ? 1000 : int'(su);
		@(posedge clock);
		base <= b;
		lat <= l;
		adc_clr <= 1'b1;
		@(posedge clock);
		adc_clr <= 1'b0;
		wr_reg(ADDR_SETTLE_LO, su[7:0]);
		wr_reg(ADDR_SETTLE_HI, {6'h00, su[9:8]});
		s0 = n_st;
		f0 = nf;
		z0 = nz;
		h0 = nh;
		wr_reg(ADDR_CTRL, c | 8'h01);
		k = 0;
		do begin
			@(posedge clock);
			#1;
			k++;
		end while (conv_start !== 1'b1 && k < 1100);
		if (k >= 1100) begin
			failures++;
			test_done();
		end
		chk("settle", 16'(k >= sx + 1 && k <= sx + 3), 16'h0001);
		rd_reg(ADDR_RESULT_LO, rl);
		rd_reg(ADDR_RESULT_HI, rh);
		if (hv)
			chk("hold", {rh, rl}, {4'h0, prev});
		wr_reg(ADDR_CTRL, (c ^ 8'h0C) | 8'h01);
		k = 0;
		do begin
			rd_reg(ADDR_STATUS, rl);
			k++;
		end while (rl[ST_BUSY] !== 1'b0 && k < 500);
		if (k >= 500) begin
			failures++;
			test_done();
		end
		rd_reg(ADDR_RESULT_LO, rl);
		rd_reg(ADDR_RESULT_HI, rh);
		chk("result", {rh, rl}, {4'h0, e});
		chk("starts", 16'(n_st - s0), c[1] ? 16'h0004 : 16'h0001);
		chk("sense", 16'({nf != f0, nz != z0, nh != h0}), 16'({!c[2] && !c[3], !c[2] && c[3], c[2] && c[3]}));
		chk("mode", 16'(adc_voltage_mode), 16'(c[2]));
		prev = e;
		hv = 1'b1;
	endtask
	task automatic t_regs();
		logic [3:0] a [5] = '{ADDR_CTRL, ADDR_THRESH_LO, ADDR_THRESH_HI, ADDR_CLKDIV, 4'hC};
		logic [7:0] e [5] = '{CTRL_RST, THRESH_RST[7:0], {4'h0, THRESH_RST[11:8]}, CLKDIV_RST, 8'h00};
		logic [7:0] d;
		for (int i = 0; i < 5; i++) begin
			rd_reg(a[i], d);
			chk("reset_reg", {8'h00, d}, {8'h00, e[i]});
		end
		$display("test regs done");
	endtask
	task automatic t_clk();
		int c0;
		c0 = n_ck;
		repeat (100) @(posedge clock);
		chk("conv_clk", 16'(n_ck - c0), 16'(100 / (2 * (int'(CLKDIV_RST) + 1))));
		$display("test clock done");
	endtask
	task automatic t_led();
		logic [7:0] d;
		for (int i = 0; i < 16; i++) begin
			wr_reg(ADDR_LED, {4'hA, 4'(i)});
			rd_reg(ADDR_LED, d);
			chk("led_reg", {8'h00, d}, 16'(i));
			chk("led_pin", {12'h000, led_current_source}, 16'(i));
		end
		$display("test led done");
	endtask
	task automatic t_seq();
		meas(8'h02, 10'd0, 12'h123, 8'd3);
		meas(8'h00, 10'd1000, 12'h456, 8'd40);
		meas(8'h0C, 10'd1023, 12'h7F0, 8'd5);
		meas(8'h0A, 10'd7, 12'hABC, 8'd9);
		meas(8'h06, 10'd2, 12'h010, 8'd4);
		$display("test sequence done");
	endtask
	task automatic t_thresh();
		logic [7:0] d;
		wr_reg(ADDR_THRESH_LO, 8'h01);
		wr_reg(ADDR_THRESH_HI, 8'h02);
		wr_reg(ADDR_IRQ_MASK, 8'h03);
		wr_reg(ADDR_IRQ_STAT, 8'h03);
		meas(8'h12, 10'd0, 12'h200, 8'd3);
		chk("disable_hit", 16'(driver_disable), 16'h0001);
		chk("irq_set", 16'(irq), 16'h0001);
		rd_reg(ADDR_IRQ_STAT, d);
		chk("irq_stat", {8'h00, d}, 16'h0003);
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		#1;
		chk("irq_masked", 16'(irq), 16'h0000);
		wr_reg(ADDR_IRQ_MASK, 8'h03);
		wr_reg(ADDR_IRQ_STAT, 8'h03);
		#1;
		chk("irq_clear", 16'(irq), 16'h0000);
		meas(8'h12, 10'd0, 12'h1FF, 8'd3);
		chk("disable_miss", 16'(driver_disable), 16'h0000);
		$display("test threshold done");
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_clk();
		t_led();
		t_seq();
		t_thresh();
		test_done();
	end
endmodule
